// File: include/crf_pkg.sv
// Shared constants and carrier types for the CPU programmer's register file
package crf_pkg;

    // ==========================================================
    // Widths, reset values and fixed addresses
    // ==========================================================
    localparam int CRF_DW = 8;
    localparam int CRF_AW = 16;
    localparam logic [7:0] CRF_H_RST = 8'h00;
    localparam logic [15:0] CRF_SP_RST = 16'h00FF;
    localparam logic [15:0] CRF_PC_RST = 16'h0000;
    localparam logic [15:0] CRF_VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] CRF_VEC_LO_ADDR = 16'hFFFF;
    localparam logic [7:0] CRF_RSP_LOW = 8'hFF;
    localparam logic [7:0] CRF_DIR_PAGE = 8'h00;
    localparam logic [2:0] CRF_CALL_BYTES = 3'h2;
    localparam logic [2:0] CRF_INT_BYTES = 3'h4;

    // ==========================================================
    // Command, address mode and low index byte operations
    // ==========================================================
    typedef enum logic [4:0] {
        CRF_NOP, CRF_FETCH, CRF_JMP, CRF_BRA, CRF_LDA, CRF_STA,
        CRF_ALUA, CRF_LDX, CRF_XOP, CRF_TAX, CRF_TXA, CRF_LDHX,
        CRF_AIS, CRF_RSP, CRF_PSH, CRF_PUL, CRF_CALL, CRF_INTR,
        CRF_RTS, CRF_MUL, CRF_DIV
    } crf_op_t;

    typedef enum logic [1:0] {
        CRF_AM_DIR, CRF_AM_EXT, CRF_AM_IX
    } crf_am_t;

    typedef enum logic [3:0] {
        CRF_X_CLR, CRF_X_INC, CRF_X_DEC, CRF_X_COM, CRF_X_NEG,
        CRF_X_LSL, CRF_X_LSR, CRF_X_ASR, CRF_X_ROL, CRF_X_ROR
    } crf_xop_t;

    // Load destination while a read is in flight
    typedef enum logic [1:0] {
        CRF_LD_A, CRF_LD_X, CRF_LD_DATA
    } crf_ld_t;

    // Gray along vector fetch into run
    typedef enum logic [2:0] {
        CRF_S_VHI = 3'b000,
        CRF_S_VLO = 3'b001,
        CRF_S_RUN = 3'b011,
        CRF_S_LOAD = 3'b010,
        CRF_S_PUSH = 3'b110,
        CRF_S_PULL = 3'b111
    } crf_st_t;

    typedef struct packed {
        crf_op_t op;
        crf_am_t am;
        crf_xop_t xop;
        logic cin;
        logic taken;
        logic [7:0] imm;
        logic [15:0] addr;
    } crf_cmd_t;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } crf_bus_t;

endpackage

// File: logic/crf_xunit.sv
// Single-operand byte unit for the low index byte
`timescale 1ns/100ps

module crf_xunit import crf_pkg::*; (
    input wire crf_xop_t op_i, // Operation select
    input wire logic [7:0] val_i, // Operand byte
    input wire logic cin_i, // Carry into rotates
    output logic [7:0] res_o // Result byte
);

    // ==========================================================
    // Clear, step, complement, negate, shift and rotate
    // ==========================================================
    always_comb begin
        case (op_i)
            CRF_X_CLR: res_o = 8'h00;
            CRF_X_INC: res_o = val_i + 8'h01;
            CRF_X_DEC: res_o = val_i - 8'h01;
            CRF_X_COM: res_o = ~val_i;
            CRF_X_NEG: res_o = ~val_i + 8'h01;
            CRF_X_LSL: res_o = {val_i[6:0], 1'b0};
            CRF_X_LSR: res_o = {1'b0, val_i[7:1]};
            CRF_X_ASR: res_o = {val_i[7], val_i[7:1]};
            CRF_X_ROL: res_o = {val_i[6:0], cin_i};
            CRF_X_ROR: res_o = {cin_i, val_i[7:1]};
            default: res_o = val_i; // Unused codes keep the byte
        endcase
    end

endmodule // crf_xunit

// File: logic/crf_regs.sv
// CPU programmer's register file: accumulator, index pair, stack and program counter
`timescale 1ns/100ps

module crf_regs import crf_pkg::*; (
    input wire logic clk_i, // Core clock
    input wire logic rstn_i, // Async reset, active low
    input wire logic cmd_vld_i, // Command present
    input wire crf_cmd_t cmd_i, // Command and operands
    input wire logic [7:0] bus_rdata_i, // Read data, same cycle as rd
    output crf_bus_t bus_o, // Memory bus request
    output logic ready_o, // Ready to take a command this cycle
    output logic [7:0] acc_o, // Accumulator
    output logic [15:0] hx_o, // Index pair
    output logic [15:0] sp_o, // Stack pointer
    output logic [15:0] pc_o, // Program counter
    output logic [7:0] data_o, // Last fetched byte
    output logic data_vld_o, // Fetched byte pulse
    output logic div_err_o // Last divide failed
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        crf_st_t st;
        logic [7:0] acc;
        logic [7:0] xh;
        logic [7:0] xl;
        logic [15:0] sp;
        logic [15:0] pc;
        crf_bus_t bus;
        crf_ld_t ld;
        logic [2:0] k;
        logic [2:0] len;
        logic [15:0] tgt;
        logic [7:0] data;
        logic dvld;
        logic derr;
        logic rdy;
    } crf_state_t;

    crf_state_t s_q;
    crf_state_t s_d;
    logic take;
    logic [15:0] hx;
    logic [15:0] ea;
    logic [15:0] imm_sx;
    logic [7:0] xres;
    logic [15:0] prod;
    logic [15:0] dvd;
    logic [7:0] dvs;
    logic [15:0] quo;
    logic [15:0] rem;

    assign take = cmd_vld_i && s_q.rdy;
    assign hx = {s_q.xh, s_q.xl};
    assign imm_sx = {{8{cmd_i.imm[7]}}, cmd_i.imm};

    // Effective address; all forms are 16-bit in one space
    always_comb begin
        if (cmd_i.am == CRF_AM_DIR) begin
            ea = {CRF_DIR_PAGE, cmd_i.imm};
        end else if (cmd_i.am == CRF_AM_IX) begin
            ea = hx + {8'h00, cmd_i.imm};
        end else begin
            ea = cmd_i.addr;
        end
    end

    // Low index byte unit
    crf_xunit u_xunit (
        .op_i(cmd_i.xop),
        .val_i(s_q.xl),
        .cin_i(cmd_i.cin),
        .res_o(xres)
    );

    // Multiply and divide; divisor forced nonzero to keep the divider defined
    assign prod = {8'h00, s_q.xl} * {8'h00, s_q.acc};
    assign dvd = {s_q.xh, s_q.acc};
    assign dvs = (s_q.xl == 8'h00) ? 8'h01 : s_q.xl;
    assign quo = dvd / {8'h00, dvs};
    assign rem = dvd % {8'h00, dvs};

    // Byte pushed at step k: return address low, high, then index, acc
    function automatic logic [7:0] push_byte(input logic [2:0] k,
            input logic [15:0] ret, input logic [7:0] x, input logic [7:0] a);
        case (k)
            3'h0: push_byte = ret[7:0];
            3'h1: push_byte = ret[15:8];
            3'h2: push_byte = x;
            default: push_byte = a;
        endcase
    endfunction

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        s_d = s_q;
        s_d.bus.rd = 1'b0;
        s_d.bus.wr = 1'b0;
        s_d.dvld = 1'b0;
        case (s_q.st)
            CRF_S_VHI: begin
                s_d.pc[15:8] = bus_rdata_i;
                s_d.bus.addr = CRF_VEC_LO_ADDR;
                s_d.bus.rd = 1'b1;
                s_d.st = CRF_S_VLO;
            end
            CRF_S_VLO: begin
                s_d.pc[7:0] = bus_rdata_i;
                s_d.st = CRF_S_RUN;
            end
            CRF_S_LOAD: begin
                if (s_q.ld == CRF_LD_A) begin
                    s_d.acc = bus_rdata_i;
                end else if (s_q.ld == CRF_LD_X) begin
                    s_d.xl = bus_rdata_i;
                end else begin
                    s_d.data = bus_rdata_i;
                    s_d.dvld = 1'b1;
                end
                s_d.st = CRF_S_RUN;
            end
            CRF_S_PUSH: begin
                // Writes at the free slot, then steps down
                s_d.bus.addr = s_q.sp;
                s_d.bus.wr = 1'b1;
                s_d.bus.wdata = push_byte(s_q.k, s_q.pc, s_q.xl, s_q.acc);
                s_d.sp = s_q.sp - 16'h0001;
                s_d.k = s_q.k + 3'h1;
                if (s_q.k + 3'h1 == s_q.len) begin
                    s_d.pc = s_q.tgt;
                    s_d.st = CRF_S_RUN;
                end
            end
            CRF_S_PULL: begin
                // High byte was pushed last, so it comes back first
                if (s_q.k == 3'h0) begin
                    s_d.pc[15:8] = bus_rdata_i;
                    s_d.bus.addr = s_q.sp + 16'h0001;
                    s_d.bus.rd = 1'b1;
                    s_d.sp = s_q.sp + 16'h0001;
                    s_d.k = 3'h1;
                end else begin
                    s_d.pc[7:0] = bus_rdata_i;
                    s_d.st = CRF_S_RUN;
                end
            end
            default: begin
                if (take) begin
                    case (cmd_i.op)
                        CRF_FETCH: begin
                            s_d.bus.addr = s_q.pc;
                            s_d.bus.rd = 1'b1;
                            s_d.pc = s_q.pc + 16'h0001;
                            s_d.ld = CRF_LD_DATA;
                            s_d.st = CRF_S_LOAD;
                        end
                        CRF_JMP: s_d.pc = cmd_i.addr;
                        CRF_BRA: begin
                            if (cmd_i.taken) begin
                                s_d.pc = s_q.pc + imm_sx;
                            end
                        end
                        CRF_LDA, CRF_LDX: begin
                            s_d.bus.addr = ea;
                            s_d.bus.rd = 1'b1;
                            s_d.ld = (cmd_i.op == CRF_LDA) ? CRF_LD_A : CRF_LD_X;
                            s_d.st = CRF_S_LOAD;
                        end
                        CRF_STA: begin
                            s_d.bus.addr = ea;
                            s_d.bus.wr = 1'b1;
                            s_d.bus.wdata = s_q.acc;
                        end
                        CRF_ALUA: s_d.acc = cmd_i.imm;
                        CRF_XOP: s_d.xl = xres;
                        CRF_TAX: s_d.xl = s_q.acc;
                        CRF_TXA: s_d.acc = s_q.xl;
                        CRF_LDHX: {s_d.xh, s_d.xl} = cmd_i.addr;
                        CRF_AIS: s_d.sp = s_q.sp + imm_sx;
                        CRF_RSP: s_d.sp[7:0] = CRF_RSP_LOW;
                        CRF_PSH: begin
                            s_d.bus.addr = s_q.sp;
                            s_d.bus.wr = 1'b1;
                            s_d.bus.wdata = s_q.acc;
                            s_d.sp = s_q.sp - 16'h0001;
                        end
                        CRF_PUL: begin
                            s_d.bus.addr = s_q.sp + 16'h0001;
                            s_d.bus.rd = 1'b1;
                            s_d.sp = s_q.sp + 16'h0001;
                            s_d.ld = CRF_LD_A;
                            s_d.st = CRF_S_LOAD;
                        end
                        CRF_CALL, CRF_INTR: begin
                            s_d.tgt = cmd_i.addr;
                            s_d.k = 3'h0;
                            s_d.len = (cmd_i.op == CRF_CALL) ? CRF_CALL_BYTES
                                : CRF_INT_BYTES;
                            s_d.st = CRF_S_PUSH;
                        end
                        CRF_RTS: begin
                            s_d.bus.addr = s_q.sp + 16'h0001;
                            s_d.bus.rd = 1'b1;
                            s_d.sp = s_q.sp + 16'h0001;
                            s_d.k = 3'h0;
                            s_d.st = CRF_S_PULL;
                        end
                        CRF_MUL: {s_d.xl, s_d.acc} = prod;
                        CRF_DIV: begin
                            // Zero divisor or wide quotient leaves A and H alone
                            if (s_q.xl == 8'h00 || quo[15:8] != 8'h00) begin
                                s_d.derr = 1'b1;
                            end else begin
                                s_d.derr = 1'b0;
                                s_d.acc = quo[7:0];
                                s_d.xh = rem[7:0];
                            end
                        end
                        default: s_d.st = CRF_S_RUN;
                    endcase
                end
            end
        endcase
        s_d.rdy = (s_d.st == CRF_S_RUN);
    end

    // ==========================================================
    // Registers; A and X keep their contents through reset
    // ==========================================================
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q.st <= CRF_S_VHI;
            s_q.xh <= CRF_H_RST;
            s_q.sp <= CRF_SP_RST;
            s_q.pc <= CRF_PC_RST;
            s_q.bus <= '{addr: CRF_VEC_HI_ADDR, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
            s_q.ld <= CRF_LD_A;
            s_q.k <= 3'h0;
            s_q.len <= 3'h0;
            s_q.tgt <= 16'h0000;
            s_q.data <= 8'h00;
            s_q.dvld <= 1'b0;
            s_q.derr <= 1'b0;
            s_q.rdy <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Register outputs; none is decoded from the bus address
    assign bus_o = s_q.bus;
    assign ready_o = s_q.rdy;
    assign acc_o = s_q.acc;
    assign hx_o = hx;
    assign sp_o = s_q.sp;
    assign pc_o = s_q.pc;
    assign data_o = s_q.data;
    assign data_vld_o = s_q.dvld;
    assign div_err_o = s_q.derr;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    rst_values_a: assert property (s_q.st == CRF_S_VHI |->
        sp_o == CRF_SP_RST && hx_o[15:8] == CRF_H_RST)
        else $error("stack or high index wrong after reset");
    vec_addr_a: assert property (s_q.st == CRF_S_VHI |->
        bus_o.rd && bus_o.addr == CRF_VEC_HI_ADDR ##1
        bus_o.rd && bus_o.addr == CRF_VEC_LO_ADDR)
        else $error("reset vector not read in order");
    vec_endian_a: assert property (s_q.st == CRF_S_VHI ##1
        s_q.st == CRF_S_VLO |=>
        pc_o == {$past(bus_rdata_i, 2), $past(bus_rdata_i)} && ready_o)
        else $error("reset vector byte order wrong");
    fetch_step_a: assert property (take && cmd_i.op == CRF_FETCH |=>
        pc_o == $past(pc_o) + 16'h0001 && bus_o.rd && bus_o.addr == $past(pc_o))
        else $error("fetch did not step counter");
    fetch_data_a: assert property (take && cmd_i.op == CRF_FETCH |=>
        ##1 data_vld_o && data_o == $past(bus_rdata_i))
        else $error("fetched byte not handed over");
    jump_load_a: assert property (take && cmd_i.op == CRF_JMP |=>
        pc_o == $past(cmd_i.addr))
        else $error("jump target not loaded");
    branch_rel_a: assert property (take && cmd_i.op == CRF_BRA |=>
        pc_o == $past(pc_o) + ($past(cmd_i.taken) ?
        {{8{$past(cmd_i.imm[7])}}, $past(cmd_i.imm)} : 16'h0000))
        else $error("branch target wrong");
    stack_adj_a: assert property (take && cmd_i.op == CRF_AIS |=>
        sp_o == $past(sp_o) + {{8{$past(cmd_i.imm[7])}}, $past(cmd_i.imm)})
        else $error("stack adjust wrong");
    stack_low_a: assert property (take && cmd_i.op == CRF_RSP |=>
        sp_o == {$past(sp_o[15:8]), CRF_RSP_LOW})
        else $error("stack low reset touched high byte");
    direct_page_a: assert property (take && cmd_i.op == CRF_LDA
        && cmd_i.am == CRF_AM_DIR |=> bus_o.addr[15:8] == CRF_DIR_PAGE)
        else $error("direct access left first page");
    index_ptr_a: assert property (take && cmd_i.op == CRF_LDA
        && cmd_i.am == CRF_AM_IX |=> bus_o.addr == $past(hx_o) + {8'h00, $past(cmd_i.imm)})
        else $error("indexed address wrong");
    mul_result_a: assert property (take && cmd_i.op == CRF_MUL |=>
        {hx_o[7:0], acc_o} == $past(hx_o[7:0]) * $past(acc_o))
        else $error("multiply result wrong");
    call_push_a: assert property (take && cmd_i.op == CRF_CALL |->
        ##3 pc_o == $past(cmd_i.addr, 3) && sp_o == $past(sp_o, 3) - 16'h0002)
        else $error("call did not push two bytes");

    vec_done_c: cover property (s_q.st == CRF_S_VLO ##1 ready_o);
    intr_c: cover property (take && cmd_i.op == CRF_INTR ##5 ready_o);
    rts_c: cover property (take && cmd_i.op == CRF_RTS ##3 ready_o);
    div_err_c: cover property ($rose(div_err_o));

endmodule // crf_regs

// File: verification/crf_mem_model.sv
// Behavioural byte memory that answers the register file's bus
`timescale 1ns/100ps

module crf_mem_model import crf_pkg::*; (
    input wire logic clk_i, // Core clock
    input wire crf_bus_t bus_i, // Request from the core
    output logic [7:0] rdata_o // Read data, same cycle as the request
);
    // ==========================================
    // Storage
    // ==========================================
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;

    // Address pattern fill, so a stray read never looks like a planted byte
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ 8'hA5;
        end
        last_q = 8'h00;
    end

    // Released bus shows the inverse of the last byte, never a friendly value
    assign rdata_o = bus_i.rd ? mem[bus_i.addr] : ~last_q;

    // Writes land on the edge that carries the strobe
    always @(posedge clk_i) begin
        if (bus_i.wr) begin
            mem[bus_i.addr] <= bus_i.wdata;
        end
        if (bus_i.rd) begin
            last_q <= mem[bus_i.addr];
        end
    end
endmodule // crf_mem_model

// File: verification/tb_top.sv
// Self-checking bench for the CPU programmer's register file
`timescale 1ns/100ps

module tb_top import crf_pkg::*;;
    typedef struct packed {
        crf_cmd_t cmd;
        logic [7:0] acc;
        logic [15:0] idx;
        logic [15:0] stk;
        logic [15:0] prog;
    } crf_row_t;

    localparam crf_am_t DIR = CRF_AM_DIR;
    logic clk_i;
    logic rstn_i;
    logic cmd_vld_i;
    crf_cmd_t cmd_i;
    logic [7:0] bus_rdata_i;
    crf_bus_t bus_o;
    logic ready_o;
    logic [7:0] acc_o;
    logic [15:0] hx_o;
    logic [15:0] sp_o;
    logic [15:0] pc_o;
    logic [7:0] data_o;
    logic data_vld_o;
    logic div_err_o;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    crf_row_t rows[$];

    crf_regs crf_regs_i (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_vld_i(cmd_vld_i), .cmd_i(cmd_i),
        .bus_rdata_i(bus_rdata_i), .bus_o(bus_o), .ready_o(ready_o), .acc_o(acc_o), .hx_o(hx_o),
        .sp_o(sp_o), .pc_o(pc_o), .data_o(data_o), .data_vld_o(data_vld_o),
        .div_err_o(div_err_o));
    crf_mem_model crf_mem_model_i (.clk_i(clk_i), .bus_i(bus_o), .rdata_o(bus_rdata_i));

    // ==========================================
    // Clock, timeout and reporting
    // ==========================================
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Whole run needs about 120 cycles; the ceiling leaves wide margin
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Packing of a: [7:0] immediate, [3:0] byte op, [4] carry in, [8] branch taken
    function automatic crf_cmd_t mk(input crf_op_t o, input crf_am_t m, input logic [15:0] a);
        return '{op: o, am: m, xop: crf_xop_t'(a[3:0]), cin: a[4], taken: a[8],
            imm: a[7:0], addr: a};
    endfunction

    task automatic add(input crf_op_t o, input crf_am_t m, input logic [15:0] a,
        input logic [7:0] ea, input logic [15:0] eh, input logic [15:0] es,
        input logic [15:0] ep);
        rows.push_back('{cmd: mk(o, m, a), acc: ea, idx: eh, stk: es, prog: ep});
    endtask

    // One idle cycle before each request, so the strobe never toggles twice at one edge
    task automatic issue(input crf_cmd_t c);
        int n;
        n = 0;
        @(negedge clk_i);
        cmd_vld_i = 1'b1;
        cmd_i = c;
        while (ready_o !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        cmd_vld_i = 1'b0;
        while (ready_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 20) chk8("ready", 8'h01, 8'h00);
    endtask

    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        rstn_i = 1'b0;
        cmd_vld_i = 1'b0;
        cmd_i = '0;
        #1;
        crf_mem_model_i.mem[16'hFFFE] = 8'h12;
        crf_mem_model_i.mem[16'hFFFF] = 8'h34;
        crf_mem_model_i.mem[16'h1234] = 8'h5A;
        crf_mem_model_i.mem[16'h0040] = 8'h11;
        crf_mem_model_i.mem[16'h0041] = 8'h22;
        crf_mem_model_i.mem[16'h2041] = 8'hEE;
        crf_mem_model_i.mem[16'h2015] = 8'h33;
        crf_mem_model_i.mem[16'h0015] = 8'hEE;
        repeat (8) @(negedge clk_i);
        chk16("stack", 16'h00FF, sp_o);
        chk8("idx_hi", 8'h00, hx_o[15:8]);
        chk16("prog", 16'h0000, pc_o);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk16("prog", 16'h1234, pc_o);
        chk8("ready", 8'h01, {7'h00, ready_o});
        issue(mk(CRF_LDHX, DIR, 16'h2010));
        issue(mk(CRF_LDA, CRF_AM_EXT, 16'h0040));
        add(CRF_FETCH, DIR, 16'h0000, 8'h11, 16'h2010, 16'h00FF, 16'h1235);
        add(CRF_LDA, DIR, 16'h0041, 8'h22, 16'h2010, 16'h00FF, 16'h1235);
        add(CRF_LDA, CRF_AM_IX, 16'h0005, 8'h33, 16'h2010, 16'h00FF, 16'h1235);
        add(CRF_XOP, DIR, 16'h0001, 8'h33, 16'h2011, 16'h00FF, 16'h1235);
        add(CRF_XOP, DIR, 16'h0000, 8'h33, 16'h2000, 16'h00FF, 16'h1235);
        add(CRF_XOP, DIR, 16'h0002, 8'h33, 16'h20FF, 16'h00FF, 16'h1235);
        add(CRF_XOP, DIR, 16'h0003, 8'h33, 16'h2000, 16'h00FF, 16'h1235);
        add(CRF_XOP, DIR, 16'h0001, 8'h33, 16'h2001, 16'h00FF, 16'h1235);
        add(CRF_XOP, DIR, 16'h0004, 8'h33, 16'h20FF, 16'h00FF, 16'h1235);
        add(CRF_XOP, DIR, 16'h0006, 8'h33, 16'h207F, 16'h00FF, 16'h1235);
        add(CRF_XOP, DIR, 16'h0005, 8'h33, 16'h20FE, 16'h00FF, 16'h1235);
        add(CRF_XOP, DIR, 16'h0007, 8'h33, 16'h20FF, 16'h00FF, 16'h1235);
        add(CRF_XOP, DIR, 16'h0008, 8'h33, 16'h20FE, 16'h00FF, 16'h1235);
        add(CRF_XOP, DIR, 16'h0019, 8'h33, 16'h20FF, 16'h00FF, 16'h1235);
        add(CRF_LDX, CRF_AM_EXT, 16'h0040, 8'h33, 16'h2011, 16'h00FF, 16'h1235);
        add(CRF_NOP, DIR, 16'h0000, 8'h33, 16'h2011, 16'h00FF, 16'h1235);
        add(CRF_TAX, DIR, 16'h0000, 8'h33, 16'h2033, 16'h00FF, 16'h1235);
        add(CRF_ALUA, DIR, 16'h0044, 8'h44, 16'h2033, 16'h00FF, 16'h1235);
        add(CRF_TXA, DIR, 16'h0000, 8'h33, 16'h2033, 16'h00FF, 16'h1235);
        add(CRF_STA, CRF_AM_EXT, 16'h0300, 8'h33, 16'h2033, 16'h00FF, 16'h1235);
        add(CRF_PSH, DIR, 16'h0000, 8'h33, 16'h2033, 16'h00FE, 16'h1235);
        add(CRF_ALUA, DIR, 16'h0055, 8'h55, 16'h2033, 16'h00FE, 16'h1235);
        add(CRF_PUL, DIR, 16'h0000, 8'h33, 16'h2033, 16'h00FF, 16'h1235);
        add(CRF_AIS, DIR, 16'h007F, 8'h33, 16'h2033, 16'h017E, 16'h1235);
        add(CRF_AIS, DIR, 16'h0090, 8'h33, 16'h2033, 16'h010E, 16'h1235);
        add(CRF_RSP, DIR, 16'h0000, 8'h33, 16'h2033, 16'h01FF, 16'h1235);
        add(CRF_JMP, DIR, 16'h3000, 8'h33, 16'h2033, 16'h01FF, 16'h3000);
        add(CRF_BRA, DIR, 16'h0180, 8'h33, 16'h2033, 16'h01FF, 16'h2F80);
        add(CRF_BRA, DIR, 16'h0010, 8'h33, 16'h2033, 16'h01FF, 16'h2F80);
        add(CRF_BRA, DIR, 16'h017F, 8'h33, 16'h2033, 16'h01FF, 16'h2FFF);
        add(CRF_MUL, DIR, 16'h0000, 8'h29, 16'h200A, 16'h01FF, 16'h2FFF);
        add(CRF_LDHX, DIR, 16'h0107, 8'h29, 16'h0107, 16'h01FF, 16'h2FFF);
        add(CRF_ALUA, DIR, 16'h008C, 8'h8C, 16'h0107, 16'h01FF, 16'h2FFF);
        add(CRF_DIV, DIR, 16'h0000, 8'h38, 16'h0407, 16'h01FF, 16'h2FFF);
        add(CRF_CALL, DIR, 16'h4000, 8'h38, 16'h0407, 16'h01FD, 16'h4000);
        add(CRF_RTS, DIR, 16'h0000, 8'h38, 16'h0407, 16'h01FF, 16'h2FFF);
        add(CRF_INTR, DIR, 16'h5000, 8'h38, 16'h0407, 16'h01FB, 16'h5000);
        // Every row runs, then all four registers are compared
        foreach (rows[i]) begin
            issue(rows[i].cmd);
            chk8("acc", rows[i].acc, acc_o);
            chk16("idx", rows[i].idx, hx_o);
            chk16("stack", rows[i].stk, sp_o);
            chk16("prog", rows[i].prog, pc_o);
        end
        // Last interrupt push is still on the bus; let it land first
        @(negedge clk_i);
        chk8("mem", 8'h33, crf_mem_model_i.mem[16'h0300]);
        chk8("mem", 8'h33, crf_mem_model_i.mem[16'h00FF]);
        chk16("mem", 16'h2FFF, {crf_mem_model_i.mem[16'h01FE],
            crf_mem_model_i.mem[16'h01FF]});
        chk16("mem", 16'h3807, {crf_mem_model_i.mem[16'h01FC],
            crf_mem_model_i.mem[16'h01FD]});
        // Divide by zero must leave both halves alone
        issue(mk(CRF_LDHX, DIR, 16'h0000));
        issue(mk(CRF_DIV, DIR, 16'h0000));
        chk8("div_err", 8'h01, {7'h00, div_err_o});
        chk8("acc", 8'h38, acc_o);
        issue(mk(CRF_LDHX, DIR, 16'h0002));
        issue(mk(CRF_DIV, DIR, 16'h0000));
        chk8("div_err", 8'h00, {7'h00, div_err_o});
        chk8("acc", 8'h1C, acc_o);
        issue(mk(CRF_JMP, DIR, 16'h1234));
        issue(mk(CRF_FETCH, DIR, 16'h0000));
        chk8("data", 8'h5A, data_o);
        chk8("data_vld", 8'h01, {7'h00, data_vld_o});
        // Mid-run reset: accumulator and low index survive, the rest is forced
        @(negedge clk_i);
        rstn_i = 1'b0;
        @(negedge clk_i);
        chk8("acc", 8'h1C, acc_o);
        chk16("idx", 16'h0002, hx_o);
        chk16("stack", 16'h00FF, sp_o);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk16("prog", 16'h1234, pc_o);
        give_verdict();
    end
endmodule // tb_top
